//--- twcra_top.sv
// Two-wire command and register-access port of a sub-GHz transmitter
`timescale 1ns/10ps
`include "twcra_params.svh"
module twcra_top
	import twcra_pkg::*;
#(
	parameter int CORE_WAIT_CYC = `TWCRA_CORE_WAIT_CYC,
	parameter int STOP_CYC      = `TWCRA_STOP_CYC
) (
	// System clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// Two-wire port pins
	input  wire logic        sclk_in,
	input  wire logic        sdata_in,
	output logic             sdata_out_q,
	output logic             sdata_oe_q,
	// Start configuration: 1 starts on a rising data edge, 0 on a falling one
	input  wire logic        start_on_rise,
	// Core side
	output logic             core_reset_q,
	output logic             calib_busy_q,
	output logic             sleep_q,
	output logic             tx_active_q,
	output logic             tx_start_q,
	output logic             edge_trig_en_q,
	output logic             link_en_q,
	// Feature register read port
	input  wire logic [4:0]  feat_rd_idx,
	output logic      [15:0] feat_rd_data
);

	// Pin synchronisation and edge finding
	logic [1:0] pins_sync;
	logic       sclk_s;
	logic       din_s;
	logic       sclk_prev_q;
	logic       din_prev_q;
	logic       sclk_fall;
	logic       sclk_rise;

	twcra_sync #(
		.WIDTH (2)
	) u_sync (
		.clk      (clk),
		.rst      (rst),
		.async_in ({~sclk_in, sdata_in}), // Clock inverted so the reset level matches its idle
		.sync_out (pins_sync)
	);

	assign sclk_s = ~pins_sync[1];
	assign din_s  = pins_sync[0];

	// Previous levels for edge detection
	always_ff @(posedge clk) begin
		if (rst) begin
			sclk_prev_q <= 1'b1; // Idle high, so no false edge after reset
			din_prev_q  <= 1'b0;
		end else begin
			sclk_prev_q <= sclk_s;
			din_prev_q  <= din_s;
		end
	end

	assign sclk_fall = sclk_prev_q & ~sclk_s;
	assign sclk_rise = ~sclk_prev_q & sclk_s;

	// Frame shifter state
	logic [15:0] shift_q;
	logic [4:0]  bit_cnt_q;
	logic [5:0]  zero_run_q;
	logic        lr_armed_q;
	logic        rd_phase_q;
	logic [7:0]  rd_shift_q;
	logic [15:0] word_d;
	logic        arm_now;
	logic        frame_done;
	logic        lr_done;
	logic        rel_done;
	logic        core_done;
	logic        wr_done;
	logic        rd_start;

	// Staging and status
	logic [7:0] feat_addr_q;
	logic [7:0] feat_low_q;
	logic [7:0] feat_high_q;
	logic       feat_wr_q;
	twcra_core_state_type state_q;
	logic [$clog2(CORE_WAIT_CYC+1)-1:0] calib_cnt_q;
	logic [$clog2(STOP_CYC+1)-1:0]      stop_cnt_q;

	// Register read decode, unmapped addresses read zero
	function automatic logic [7:0] reg_read(input logic [5:0] addr);
		logic [7:0] v;
		v = 8'h00;
		case (addr)
			`TWCRA_ADDR_FEAT_ADDR: v = feat_addr_q;
			`TWCRA_ADDR_FEAT_LOW:  v = feat_low_q;
			`TWCRA_ADDR_FEAT_HIGH: v = feat_high_q;
			`TWCRA_ADDR_STATUS: begin
				v[`TWCRA_ST_SLEEP]   = sleep_q;
				v[`TWCRA_ST_CALIB]   = calib_busy_q;
				v[`TWCRA_ST_TX]      = tx_active_q;
				v[`TWCRA_ST_EDGE_EN] = edge_trig_en_q;
				v[`TWCRA_ST_LINK_EN] = link_en_q;
			end
			default: v = 8'h00;
		endcase
		return v;
	endfunction

	// Frame decode from the bit being sampled now
	assign word_d     = {shift_q[14:0], din_s};
	assign arm_now    = sclk_fall && din_s && (zero_run_q == `TWCRA_ZERO_RUN);
	assign frame_done = sclk_fall && !arm_now && (bit_cnt_q == `TWCRA_LAST_BIT);
	assign lr_done    = frame_done && lr_armed_q && (word_d == `TWCRA_CMD_LINK_RST);
	assign rel_done   = frame_done && link_en_q && !lr_done
		&& (word_d == `TWCRA_CMD_LINK_REL);
	assign core_done  = frame_done && link_en_q && !lr_done
		&& (word_d == `TWCRA_CMD_CORE_RST);
	assign wr_done    = frame_done && link_en_q && !lr_done && !rel_done && !core_done
		&& (word_d[15:14] == 2'b10);
	assign rd_start   = sclk_fall && !arm_now && link_en_q
		&& (bit_cnt_q == `TWCRA_PRE_HALF_BIT) && (word_d[7:6] == 2'b11);

	// Run of low samples; saturates so a long low stretch still qualifies
	always_ff @(posedge clk) begin
		if (rst) begin
			zero_run_q <= 6'h00;
		end else if (sclk_fall) begin
			if (din_s) begin
				zero_run_q <= 6'h00;
			end else if (zero_run_q != `TWCRA_ZERO_RUN) begin
				zero_run_q <= zero_run_q + 6'h01;
			end
		end
	end

	// Bit counter and shifter; a qualifying low run restarts the frame
	always_ff @(posedge clk) begin
		if (rst) begin
			shift_q    <= 16'h0000;
			bit_cnt_q  <= 5'h00;
			lr_armed_q <= 1'b0;
		end else if (arm_now) begin
			shift_q    <= 16'h0001;
			bit_cnt_q  <= 5'h01;
			lr_armed_q <= 1'b1;
		end else if (frame_done) begin
			shift_q    <= word_d;
			bit_cnt_q  <= 5'h00;
			lr_armed_q <= 1'b0;
		end else if (sclk_fall) begin
			shift_q    <= word_d;
			bit_cnt_q  <= bit_cnt_q + 5'h01;
		end
	end

	// Link enable and edge start enable
	always_ff @(posedge clk) begin
		if (rst) begin
			link_en_q      <= 1'b1;
			edge_trig_en_q <= 1'b0;
		end else if (lr_done) begin
			link_en_q      <= 1'b1;
			edge_trig_en_q <= 1'b0;
		end else if (rel_done) begin
			link_en_q      <= 1'b0;
			edge_trig_en_q <= 1'b1;
		end
	end

	// Read data phase: drive on host rising edges, release at frame end
	always_ff @(posedge clk) begin
		if (rst) begin
			rd_phase_q  <= 1'b0;
			rd_shift_q  <= 8'h00;
			sdata_out_q <= 1'b0;
			sdata_oe_q  <= 1'b0;
		end else if (frame_done || arm_now) begin
			rd_phase_q  <= 1'b0;
			sdata_oe_q  <= 1'b0;
			sdata_out_q <= 1'b0;
		end else if (rd_start) begin
			rd_phase_q  <= 1'b1;
			rd_shift_q  <= reg_read(word_d[5:0]);
		end else if (rd_phase_q && sclk_rise) begin
			sdata_oe_q  <= 1'b1;
			sdata_out_q <= rd_shift_q[7];
			rd_shift_q  <= {rd_shift_q[6:0], 1'b0};
		end
	end

	// Staging registers; core reset clears them with the rest of the core
	always_ff @(posedge clk) begin
		if (rst || core_reset_q) begin
			feat_addr_q <= `TWCRA_STAGE_RESET;
			feat_low_q  <= `TWCRA_STAGE_RESET;
			feat_high_q <= `TWCRA_STAGE_RESET;
		end else if (wr_done) begin
			case (word_d[13:8])
				`TWCRA_ADDR_FEAT_ADDR: feat_addr_q <= word_d[7:0];
				`TWCRA_ADDR_FEAT_LOW:  feat_low_q  <= word_d[7:0];
				`TWCRA_ADDR_FEAT_HIGH: feat_high_q <= word_d[7:0];
				default: ;
			endcase
		end
	end

	// Commit strobe; staged address beyond the bank is dropped
	always_ff @(posedge clk) begin
		if (rst) begin
			feat_wr_q <= 1'b0;
		end else begin
			feat_wr_q <= wr_done && (word_d[13:8] == `TWCRA_ADDR_COMMIT)
				&& (word_d[7:0] == `TWCRA_COMMIT_VAL)
				&& (feat_addr_q <= `TWCRA_FEAT_LAST);
		end
	end

	twcra_feature_bank #(
		.WIDTH (`TWCRA_FEAT_WIDTH),
		.DEPTH (`TWCRA_FEAT_COUNT)
	) u_bank (
		.clk     (clk),
		.rst     (rst),
		.clear   (core_reset_q),
		.wr_en   (feat_wr_q),
		.wr_idx  (feat_addr_q[4:0]),
		.wr_data ({feat_high_q, feat_low_q}),
		.rd_idx  (feat_rd_idx),
		.rd_data (feat_rd_data)
	);

	// One-cycle core reset pulse
	always_ff @(posedge clk) begin
		if (rst) begin
			core_reset_q <= 1'b0;
		end else begin
			core_reset_q <= core_done;
		end
	end

	// Core activity: edge start, stop by low data, calibration after core reset
	always_ff @(posedge clk) begin
		if (rst) begin
			state_q     <= TWCRA_CORE_SLEEP;
			calib_cnt_q <= '0;
			stop_cnt_q  <= '0;
		end else if (core_done) begin
			state_q     <= TWCRA_CORE_CALIB;
			calib_cnt_q <= '0;
			stop_cnt_q  <= '0;
		end else begin
			unique case (state_q)
				TWCRA_CORE_SLEEP: begin
					stop_cnt_q <= '0;
					if (edge_trig_en_q && (start_on_rise ? (din_s && !din_prev_q)
						: (!din_s && din_prev_q))) begin
						state_q <= TWCRA_CORE_TX;
					end
				end
				TWCRA_CORE_CALIB: begin
					if (int'(calib_cnt_q) == CORE_WAIT_CYC - 1) begin
						state_q <= TWCRA_CORE_SLEEP;
					end else begin
						calib_cnt_q <= calib_cnt_q + 1'b1;
					end
				end
				TWCRA_CORE_TX: begin
					if (din_s) begin
						stop_cnt_q <= '0;
					end else if (int'(stop_cnt_q) == STOP_CYC - 1) begin
						state_q <= TWCRA_CORE_SLEEP;
					end else begin
						stop_cnt_q <= stop_cnt_q + 1'b1;
					end
				end
				default: state_q <= TWCRA_CORE_SLEEP;
			endcase
		end
	end

	// Core status outputs registered from the current state, one cycle behind it
	always_ff @(posedge clk) begin
		if (rst) begin
			sleep_q      <= 1'b1;
			calib_busy_q <= 1'b0;
			tx_active_q  <= 1'b0;
			tx_start_q   <= 1'b0;
		end else begin
			sleep_q      <= (state_q == TWCRA_CORE_SLEEP);
			calib_busy_q <= (state_q == TWCRA_CORE_CALIB);
			tx_active_q  <= (state_q == TWCRA_CORE_TX);
			tx_start_q   <= (state_q == TWCRA_CORE_TX) && !tx_active_q;
		end
	end

	// Checks
	AST_LINK_RST_RESTART: assert property (@(posedge clk) disable iff (rst)
		lr_done |=> (bit_cnt_q == 5'h00) && link_en_q && !edge_trig_en_q)
		else $error("link reset did not restart the frame");
	AST_RELEASE_EDGE: assert property (@(posedge clk) disable iff (rst)
		rel_done |=> !link_en_q && edge_trig_en_q ##1 edge_trig_en_q)
		else $error("link release did not enable edge start");
	AST_CORE_RST_CALIB: assert property (@(posedge clk) disable iff (rst)
		core_done |=> core_reset_q && (state_q == TWCRA_CORE_CALIB) ##1 calib_busy_q)
		else $error("core reset did not start calibration");
	AST_CALIB_TO_SLEEP: assert property (@(posedge clk) disable iff (rst)
		(state_q == TWCRA_CORE_CALIB) && (int'(calib_cnt_q) == CORE_WAIT_CYC - 1)
		&& !core_done |=> ##1 sleep_q && !calib_busy_q)
		else $error("device not asleep after core reset wait");
	AST_SAMPLE_ON_FALL: assert property (@(posedge clk) disable iff (rst)
		!sclk_fall |=> $stable(bit_cnt_q) && $stable(shift_q))
		else $error("frame advanced without a clock falling edge");
	AST_READ_DRIVE: assert property (@(posedge clk) disable iff (rst)
		rd_phase_q && sclk_rise && !frame_done |=> sdata_oe_q
		&& (sdata_out_q == $past(rd_shift_q[7])))
		else $error("read data bit not driven");
	AST_FRAME_RELEASE: assert property (@(posedge clk) disable iff (rst)
		frame_done |=> !sdata_oe_q && !rd_phase_q)
		else $error("data line not released at frame end");
	AST_WRITE_LOW: assert property (@(posedge clk) disable iff (rst)
		wr_done && (word_d[13:8] == `TWCRA_ADDR_FEAT_LOW)
		|=> feat_low_q == $past(word_d[7:0]))
		else $error("low staging byte not stored");
	AST_COMMIT: assert property (@(posedge clk) disable iff (rst)
		wr_done && (word_d[13:8] == `TWCRA_ADDR_COMMIT)
		&& (word_d[7:0] == `TWCRA_COMMIT_VAL) && (feat_addr_q <= `TWCRA_FEAT_LAST)
		|=> feat_wr_q)
		else $error("commit did not write the feature register");
	AST_STOP_SLEEP: assert property (@(posedge clk) disable iff (rst)
		(state_q == TWCRA_CORE_TX) && !din_s && (int'(stop_cnt_q) == STOP_CYC - 1)
		&& !core_done |=> ##1 sleep_q && !tx_active_q)
		else $error("stop interval did not put device to sleep");
	AST_LINK_EXCLUSIVE: assert property (@(posedge clk) disable iff (rst)
		!(link_en_q && edge_trig_en_q))
		else $error("link and edge start enabled together");

endmodule // twcra_top

//--- twcra_params.svh
// Constants of the two-wire command and register-access port
`ifndef TWCRA_PARAMS_SVH
`define TWCRA_PARAMS_SVH

// System clock rate and documented times in their own units
`define TWCRA_CLK_MHZ         100
`define TWCRA_CORE_WAIT_US    1000
`define TWCRA_STOP_MS         2
`define TWCRA_CORE_WAIT_CYC   (`TWCRA_CORE_WAIT_US * `TWCRA_CLK_MHZ)
`define TWCRA_STOP_CYC        (`TWCRA_STOP_MS * 1000 * `TWCRA_CLK_MHZ)

// Frame shape
`define TWCRA_FRAME_BITS      5'h10
`define TWCRA_HALF_BITS       5'h08
`define TWCRA_LAST_BIT        5'h0F
`define TWCRA_PRE_HALF_BIT    5'h07
`define TWCRA_ZERO_RUN        6'h20

// Special command words
`define TWCRA_CMD_LINK_RST    16'h8D00
`define TWCRA_CMD_LINK_REL    16'h8D02
`define TWCRA_CMD_CORE_RST    16'hBD01

// Register addresses and values
`define TWCRA_ADDR_FEAT_ADDR  6'h18
`define TWCRA_ADDR_FEAT_LOW   6'h19
`define TWCRA_ADDR_FEAT_HIGH  6'h1A
`define TWCRA_ADDR_COMMIT     6'h25
`define TWCRA_ADDR_STATUS     6'h26
`define TWCRA_COMMIT_VAL      8'h01
`define TWCRA_STAGE_RESET     8'h00

// Feature register bank
`define TWCRA_FEAT_COUNT      21
`define TWCRA_FEAT_LAST       8'h15
`define TWCRA_FEAT_WIDTH      16

// Status register bit positions
`define TWCRA_ST_SLEEP        0
`define TWCRA_ST_CALIB        1
`define TWCRA_ST_TX           2
`define TWCRA_ST_EDGE_EN      3
`define TWCRA_ST_LINK_EN      4

`endif

//--- twcra_pkg.sv
// Types shared by the two-wire command and register-access port
package twcra_pkg;

	// Core activity of the transmitter seen by this port
	typedef enum logic [1:0] {
		TWCRA_CORE_SLEEP = 2'b00,
		TWCRA_CORE_CALIB = 2'b01,
		TWCRA_CORE_TX    = 2'b10
	} twcra_core_state_type;

endpackage

//--- twcra_sync.sv
// Two-flop synchroniser for pin levels
`timescale 1ns/10ps
module twcra_sync #(
	parameter int WIDTH = 2
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst,
	// Asynchronous levels in, synchronised levels out
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_q;

	// First stage feeds only the second stage
	always_ff @(posedge clk) begin
		if (rst) begin
			meta_q   <= '0;
			sync_out <= '0;
		end else begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end

endmodule // twcra_sync

//--- twcra_feature_bank.sv
// Bank of 16-bit feature registers written by commit
`timescale 1ns/10ps
module twcra_feature_bank #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 21
) (
	// Clock and reset
	input  wire logic                     clk,
	input  wire logic                     rst,
	// Core reset clears the bank
	input  wire logic                     clear,
	// Write port
	input  wire logic                     wr_en,
	input  wire logic [$clog2(DEPTH)-1:0] wr_idx,
	input  wire logic [WIDTH-1:0]         wr_data,
	// Read port for the transmitter core
	input  wire logic [$clog2(DEPTH)-1:0] rd_idx,
	output logic      [WIDTH-1:0]         rd_data
);

	logic [WIDTH-1:0] mem_q [DEPTH];

	// Storage; reset or core reset returns every entry to zero
	always_ff @(posedge clk) begin
		if (rst || clear) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_q[i] <= '0;
			end
		end else if (wr_en && (int'(wr_idx) < DEPTH)) begin
			mem_q[wr_idx] <= wr_data;
		end
	end

	// Registered read; out-of-range index reads zero
	always_ff @(posedge clk) begin
		if (rst) begin
			rd_data <= '0;
		end else if (int'(rd_idx) < DEPTH) begin
			rd_data <= mem_q[rd_idx];
		end else begin
			rd_data <= '0;
		end
	end

endmodule // twcra_feature_bank

//--- twcra_host.sv
// Host controller model that drives the two-wire port
`timescale 1ns/10ps
`include "twcra_params.svh"
module twcra_host (
	// Serial pins from the host
	output logic      sclk,
	output logic      sdata_drv,
	output logic      sdata_drv_en,
	// Resolved data wire
	input  wire logic sdata_wire
);
	// Half period of the 125 ns link clock
	localparam real HALF = 62.5;

	// Clock rests high, so no edges appear outside frames
	initial begin
		sclk = 1'b1;
		sdata_drv = 1'b0;
		sdata_drv_en = 1'b0;
	end

	// One bit: data changes with the rise, device samples at the fall
	// Non-blocking, since some link edges land on a system clock edge
	task automatic put_bit(input logic b);
		sclk <= 1'b1;
		sdata_drv <= b;
		sdata_drv_en <= 1'b1;
		#HALF;
		sclk <= 1'b0;
		#HALF;
	endtask

	// Whole word MSB first, then line released to its pulled-low idle
	// Clock rests high a half period so back-to-back calls never collide
	task automatic send(input logic [47:0] w, input int n);
		for (int i = n - 1; i >= 0; i--) put_bit(w[i]);
		sclk <= 1'b1;
		sdata_drv_en <= 1'b0;
		#HALF;
	endtask

	// Low run then reset word; no first-clock delay in rising-edge mode
	task automatic link_reset();
		send({32'h0, `TWCRA_CMD_LINK_RST}, 48);
	endtask

	task automatic link_release();
		send({32'h0, `TWCRA_CMD_LINK_REL}, 16);
	endtask

	task automatic core_reset();
		send({32'h0, `TWCRA_CMD_CORE_RST}, 16);
	endtask

	task automatic write_reg(input logic [5:0] a, input logic [7:0] d);
		send({32'h0, 2'b10, a, d}, 16);
	endtask

	// Driver let go at the rise that opens the data phase
	task automatic read_reg(input logic [5:0] a, output logic [7:0] d);
		for (int i = 7; i >= 0; i--) put_bit(i > 5 ? 1'b1 : a[i]);
		for (int i = 7; i >= 0; i--) begin
			sclk <= 1'b1;
			sdata_drv_en <= 1'b0;
			#HALF;
			sclk <= 1'b0;
			d[i] = sdata_wire;
			#HALF;
		end
		sclk <= 1'b1;
		#HALF;
	endtask

	// Plain level on the data pin while the clock rests high
	task automatic drive_level(input logic b);
		sdata_drv <= b;
		sdata_drv_en <= 1'b1;
	endtask
endmodule // twcra_host

//--- twcra_top_tb.sv
// Self-checking bench for the two-wire command and register port
`timescale 1ns/10ps
module twcra_top_tb;
	import twcra_pkg::*;

	logic        clk = 1'b0;
	logic        rst;
	logic        start_on_rise;
	logic [4:0]  feat_rd_idx;
	logic        sclk;
	logic        host_d;
	logic        host_en;
	logic        sdata_wire;
	logic        sdata_out_q;
	logic        sdata_oe_q;
	logic        core_reset_q;
	logic        calib_busy_q;
	logic        sleep_q;
	logic        tx_active_q;
	logic        tx_start_q;
	logic        edge_trig_en_q;
	logic        link_en_q;
	logic [15:0] feat_rd_data;
	int          fail_count = 0;
	int          checks_done = 0;
	int          n_core = 0;
	int          n_tx = 0;

	// 100 MHz system clock
	always #5 clk = ~clk;

	// Wire level: driver wins, then the device output, otherwise the pull-down
	assign sdata_wire = host_en ? host_d : (sdata_oe_q ? sdata_out_q : 1'b0);

	twcra_top #(.CORE_WAIT_CYC(50), .STOP_CYC(40)) DUT (
		.clk(clk), .rst(rst), .sclk_in(sclk), .sdata_in(sdata_wire),
		.sdata_out_q(sdata_out_q), .sdata_oe_q(sdata_oe_q),
		.start_on_rise(start_on_rise), .core_reset_q(core_reset_q),
		.calib_busy_q(calib_busy_q), .sleep_q(sleep_q), .tx_active_q(tx_active_q),
		.tx_start_q(tx_start_q), .edge_trig_en_q(edge_trig_en_q),
		.link_en_q(link_en_q), .feat_rd_idx(feat_rd_idx), .feat_rd_data(feat_rd_data)
	);

	twcra_host HOST (
		.sclk(sclk), .sdata_drv(host_d), .sdata_drv_en(host_en),
		.sdata_wire(sdata_wire)
	);

	// Pulses are one cycle wide, so count them rather than catch them
	always @(posedge clk) begin
		if (core_reset_q === 1'b1) n_core <= n_core + 1;
		if (tx_start_q === 1'b1) n_tx <= n_tx + 1;
	end

	task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_flag(input logic got, input logic exp);
		chk_val({15'h0000, got}, {15'h0000, exp});
	endtask

	// Read a register, then see the device let go of the line
	task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp);
		logic [7:0] d;
		HOST.read_reg(a, d);
		chk_val({8'h00, d}, {8'h00, exp});
		repeat (4) @(posedge clk);
		chk_flag(sdata_oe_q, 1'b0);
	endtask

	task automatic feat_chk(input logic [4:0] i, input logic [15:0] exp);
		@(posedge clk);
		feat_rd_idx <= i;
		repeat (3) @(posedge clk);
		chk_val(feat_rd_data, exp);
	endtask

	task automatic final_report();
		$display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Hang guard, well beyond the expected run of about 70 us
	initial begin
		#500000;
		fail_count++;
		final_report;
	end

	// Main sequence
	initial begin
		rst = 1'b1;
		start_on_rise = 1'b1;
		feat_rd_idx = 5'h00;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		chk_flag(sleep_q, 1'b1);
		chk_flag(link_en_q, 1'b1);
		chk_flag(edge_trig_en_q, 1'b0);
		// Power-up bracket: link reset then core reset
		HOST.link_reset();
		HOST.core_reset();
		repeat (3) @(posedge clk);
		chk_val(n_core[15:0], 16'h0001);
		chk_flag(calib_busy_q, 1'b1);
		repeat (60) @(posedge clk);
		chk_flag(sleep_q, 1'b1);
		chk_flag(calib_busy_q, 1'b0);
		// Staging, a wrong commit value, a staged address beyond the bank, then the real commit
		HOST.write_reg(6'h18, 8'h02);
		HOST.write_reg(6'h19, 8'hF6);
		HOST.write_reg(6'h1A, 8'hC3);
		rd_chk(6'h19, 8'hF6);
		rd_chk(6'h1A, 8'hC3);
		HOST.write_reg(6'h25, 8'h02);
		feat_chk(5'h02, 16'h0000);
		HOST.write_reg(6'h18, 8'h22);
		HOST.write_reg(6'h25, 8'h01);
		feat_chk(5'h02, 16'h0000);
		HOST.write_reg(6'h18, 8'h02);
		HOST.write_reg(6'h25, 8'h01);
		feat_chk(5'h02, 16'hC3F6);
		HOST.write_reg(6'h18, 8'h14);
		HOST.write_reg(6'h25, 8'h01);
		feat_chk(5'h14, 16'hC3F6);
		// Unmapped place and the status byte
		HOST.write_reg(6'h12, 8'hAA);
		rd_chk(6'h12, 8'h00);
		rd_chk(6'h26, 8'h11);
		// Broken frame, then resync by link reset
		HOST.send(48'h16, 5);
		HOST.link_reset();
		HOST.write_reg(6'h19, 8'h5A);
		rd_chk(6'h19, 8'h5A);
		// Transmission bracketed by link commands
		HOST.link_reset();
		HOST.link_release();
		repeat (3) @(posedge clk);
		chk_flag(link_en_q, 1'b0);
		chk_flag(edge_trig_en_q, 1'b1);
		HOST.drive_level(1'b1);
		repeat (10) @(posedge clk);
		chk_flag(tx_active_q, 1'b1);
		chk_val(n_tx[15:0], 16'h0001);
		HOST.drive_level(1'b0);
		repeat (55) @(posedge clk);
		chk_flag(sleep_q, 1'b1);
		chk_flag(tx_active_q, 1'b0);
		// Same stop path, started by a falling data edge
		start_on_rise <= 1'b0;
		HOST.drive_level(1'b1);
		repeat (10) @(posedge clk);
		chk_flag(tx_active_q, 1'b0);
		HOST.drive_level(1'b0);
		repeat (10) @(posedge clk);
		chk_flag(tx_active_q, 1'b1);
		chk_val(n_tx[15:0], 16'h0002);
		repeat (45) @(posedge clk);
		chk_flag(sleep_q, 1'b1);
		HOST.link_reset();
		repeat (3) @(posedge clk);
		chk_flag(link_en_q, 1'b1);
		chk_flag(edge_trig_en_q, 1'b0);
		HOST.core_reset();
		repeat (60) @(posedge clk);
		chk_val(n_core[15:0], 16'h0002);
		rd_chk(6'h19, 8'h00);
		final_report;
	end
endmodule // twcra_top_tb
